// ---- logic/psr_pkg.sv ----
/*
 package of the peripheral soft reset control block: register offsets,
 field positions, reset values and implemented-bit masks.
 assumes nothing of its surroundings.
*/
`default_nettype none
package psr_pkg;
	localparam logic [11:0] PSR_OFF_CTRL_A = 12'h044;
	localparam logic [11:0] PSR_OFF_CTRL_B = 12'h048;
	localparam logic [31:0] PSR_CTRL_A_RESET = 32'h00000000;
	localparam logic [31:0] PSR_CTRL_B_RESET = 32'h00000000;
	localparam int PSR_BIT_COMPARATOR_ZERO_RESET = 24;
	localparam int PSR_BIT_GPT2 = 18;
	localparam int PSR_BIT_GPT1 = 17;
	localparam int PSR_BIT_GPT0 = 16;
	localparam int PSR_BIT_QUAD0 = 8;
	localparam int PSR_BIT_SSP0 = 4;
	localparam int PSR_BIT_SER1 = 1;
	localparam int PSR_BIT_SER0 = 0;
	localparam int PSR_PORT_COUNT = 5;
	localparam logic [31:0] PSR_CTRL_A_IMPL = 32'h01070113;
	localparam logic [31:0] PSR_CTRL_B_IMPL = 32'h0000001F;
	localparam logic [1:0] PSR_RESP_OKAY = 2'h0;
	localparam logic [1:0] PSR_RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		PSR_W_IDLE = 2'b01,
		PSR_W_RESP = 2'b10
	} psr_wstate_e;
	typedef enum logic [1:0] {
		PSR_R_IDLE = 2'b01,
		PSR_R_DATA = 2'b10
	} psr_rstate_e;
endpackage
`default_nettype wire

// ---- logic/psr_reg_word.sv ----
/*
 one masked control word: a write changes only bits allowed by both the
 implemented mask and the capability word.
 assumes the caller decodes the address and gives a one-cycle write strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module psr_reg_word #(
	parameter logic [31:0] IMPL = 32'h0,
	parameter logic [31:0] RESET_VALUE = 32'h0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic wr_en,
	input wire logic [31:0] wr_data,
	input wire logic [3:0] wr_strb,
	input wire logic [31:0] cap,
	output logic [31:0] value_q
);
	logic [31:0] lane_m;
	logic [31:0] allow_m;
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			lane_m[i] = wr_strb[i / 8];
		end
		allow_m = IMPL & cap & lane_m;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			value_q <= RESET_VALUE;
		end else if (wr_en) begin
			// absent peripherals and unused bits keep their zero
			value_q <= (value_q & ~allow_m) | (wr_data & allow_m);
		end
	end
endmodule
`default_nettype wire

// ---- logic/psr_ctrl.sv ----
/*
 peripheral soft reset controller: two control words on an AXI4-Lite
 slave, each implemented bit holding one peripheral in reset while set.
 assumes capability words are static inputs synchronous to aclk and that
 peripherals take an active-high reset level.
*/
// The implementer's own choice: register access over AXI4-Lite.
// Operation
// - writes to control word a are masked by capability word two
// - writes to control word b are masked by capability word four
// - bit 24 of word a resets comparator zero
// - bits 18..16 of word a reset counters two, one, zero
// - bit 8 of word a resets quadrature decoder zero
// - bit 4 of word a resets synchronous serial port zero
// - bits 1 and 0 of word a reset serial ports one and zero
// - bits 4..0 of word b reset ports e, d, c, b, a
// - unused bits read zero and ignore writes
// - both words reset to zero
`timescale 1ns/1ps
`default_nettype none
module psr_ctrl
	import psr_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] capability_word_two,
	input wire logic [31:0] capability_word_four,
	output logic comparator_zero_reset,
	output logic gp_counter_two_reset,
	output logic gp_counter_one_reset,
	output logic gp_counter_zero_reset,
	output logic quad_decoder_zero_reset,
	output logic sync_serial_zero_reset,
	output logic serial_port_one_reset,
	output logic serial_port_zero_reset,
	output logic [PSR_PORT_COUNT-1:0] port_reset
);
	typedef struct packed {
		psr_wstate_e ws;
		logic aw_have;
		logic w_have;
		logic [ADDR_W-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		psr_rstate_e rs;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic wr_a;
		logic wr_b;
		logic awready;
		logic wready;
		logic arready;
		logic [8+PSR_PORT_COUNT-1:0] rst;
	} psr_state_s;

	psr_state_s st_q;
	psr_state_s st_d;
	logic [31:0] ctrl_a_q;
	logic [31:0] ctrl_b_q;
	logic [ADDR_W-1:0] wa;
	logic [ADDR_W-1:0] ra;

	always_comb begin
		st_d = st_q;
		wa = '0;
		ra = '0;
		st_d.wr_a = 1'b0;
		st_d.wr_b = 1'b0;
		case (st_q.ws)
			PSR_W_IDLE: begin
				if (s_axi_awvalid && !st_q.aw_have) begin
					st_d.aw_have = 1'b1;
					st_d.awaddr = s_axi_awaddr;
				end
				if (s_axi_wvalid && !st_q.w_have) begin
					st_d.w_have = 1'b1;
					st_d.wdata = s_axi_wdata;
					st_d.wstrb = s_axi_wstrb;
				end
				if (st_q.aw_have && st_q.w_have) begin
					wa = st_q.awaddr;
					st_d.aw_have = 1'b0;
					st_d.w_have = 1'b0;
					st_d.bvalid = 1'b1;
					st_d.ws = PSR_W_RESP;
					if (wa == PSR_OFF_CTRL_A[ADDR_W-1:0]) begin
						st_d.wr_a = 1'b1;
						st_d.bresp = PSR_RESP_OKAY;
					end else if (wa == PSR_OFF_CTRL_B[ADDR_W-1:0]) begin
						st_d.wr_b = 1'b1;
						st_d.bresp = PSR_RESP_OKAY;
					end else begin
						st_d.bresp = PSR_RESP_SLVERR;
					end
				end
			end
			PSR_W_RESP: begin
				if (s_axi_bready) begin
					st_d.bvalid = 1'b0;
					st_d.ws = PSR_W_IDLE;
				end
			end
			default: begin
				st_d.ws = PSR_W_IDLE;
			end
		endcase
		case (st_q.rs)
			PSR_R_IDLE: begin
				if (s_axi_arvalid) begin
					ra = s_axi_araddr;
					st_d.rvalid = 1'b1;
					st_d.rs = PSR_R_DATA;
					// reserved bits are zero in the stored word already
					if (ra == PSR_OFF_CTRL_A[ADDR_W-1:0]) begin
						st_d.rdata = ctrl_a_q;
						st_d.rresp = PSR_RESP_OKAY;
					end else if (ra == PSR_OFF_CTRL_B[ADDR_W-1:0]) begin
						st_d.rdata = ctrl_b_q;
						st_d.rresp = PSR_RESP_OKAY;
					end else begin
						st_d.rdata = 32'h00000000;
						st_d.rresp = PSR_RESP_SLVERR;
					end
				end
			end
			PSR_R_DATA: begin
				if (s_axi_rready) begin
					st_d.rvalid = 1'b0;
					st_d.rs = PSR_R_IDLE;
				end
			end
			default: begin
				st_d.rs = PSR_R_IDLE;
			end
		endcase
		// reset lines lag the words by one edge so each output is a flop
		st_d.rst[7] = ctrl_a_q[PSR_BIT_COMPARATOR_ZERO_RESET];
		st_d.rst[6] = ctrl_a_q[PSR_BIT_GPT2];
		st_d.rst[5] = ctrl_a_q[PSR_BIT_GPT1];
		st_d.rst[4] = ctrl_a_q[PSR_BIT_GPT0];
		st_d.rst[3] = ctrl_a_q[PSR_BIT_QUAD0];
		st_d.rst[2] = ctrl_a_q[PSR_BIT_SSP0];
		st_d.rst[1] = ctrl_a_q[PSR_BIT_SER1];
		st_d.rst[0] = ctrl_a_q[PSR_BIT_SER0];
		st_d.rst[8+PSR_PORT_COUNT-1:8] =
			ctrl_b_q[PSR_PORT_COUNT-1:0];
		// readies registered from the next state, not decoded after it
		st_d.awready = (st_d.ws == PSR_W_IDLE) && !st_d.aw_have;
		st_d.wready = (st_d.ws == PSR_W_IDLE) && !st_d.w_have;
		st_d.arready = (st_d.rs == PSR_R_IDLE);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= '{ws: PSR_W_IDLE, rs: PSR_R_IDLE, bresp: PSR_RESP_OKAY,
				rresp: PSR_RESP_OKAY, awready: 1'b1, wready: 1'b1,
				arready: 1'b1, default: '0};
		end else begin
			st_q <= st_d;
		end
	end

	psr_reg_word #(
		.IMPL(PSR_CTRL_A_IMPL),
		.RESET_VALUE(PSR_CTRL_A_RESET)
	) u_word_a (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(st_q.wr_a),
		.wr_data(st_q.wdata),
		.wr_strb(st_q.wstrb),
		.cap(capability_word_two),
		.value_q(ctrl_a_q)
	);

	psr_reg_word #(
		.IMPL(PSR_CTRL_B_IMPL),
		.RESET_VALUE(PSR_CTRL_B_RESET)
	) u_word_b (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(st_q.wr_b),
		.wr_data(st_q.wdata),
		.wr_strb(st_q.wstrb),
		.cap(capability_word_four),
		.value_q(ctrl_b_q)
	);

	// one cycle of latency on assert and release of every reset line
	assign comparator_zero_reset = st_q.rst[7];
	assign gp_counter_two_reset = st_q.rst[6];
	assign gp_counter_one_reset = st_q.rst[5];
	assign gp_counter_zero_reset = st_q.rst[4];
	assign quad_decoder_zero_reset = st_q.rst[3];
	assign sync_serial_zero_reset = st_q.rst[2];
	assign serial_port_one_reset = st_q.rst[1];
	assign serial_port_zero_reset = st_q.rst[0];
	assign port_reset = st_q.rst[8+PSR_PORT_COUNT-1:8];

	assign s_axi_awready = st_q.awready;
	assign s_axi_wready = st_q.wready;
	assign s_axi_bvalid = st_q.bvalid;
	assign s_axi_bresp = st_q.bresp;
	assign s_axi_arready = st_q.arready;
	assign s_axi_rvalid = st_q.rvalid;
	assign s_axi_rdata = st_q.rdata;
	assign s_axi_rresp = st_q.rresp;
endmodule
`default_nettype wire

// ---- sim/psr_checker.sv ----
/* checker of the reset control block.
 sees only top ports; bound into psr_ctrl below. */
`timescale 1ns/1ps
`default_nettype none
module psr_checker
	import psr_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [31:0] capability_word_two,
	input wire logic [31:0] capability_word_four,
	input wire logic comparator_zero_reset,
	input wire logic gp_counter_two_reset,
	input wire logic [4:0] port_reset
);
	logic [6:0] outs;
	assign outs = {comparator_zero_reset, gp_counter_two_reset, port_reset};
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_rst_clear: assert property ($rose(aresetn) |->
		outs == 7'h00 && !s_axi_bvalid) else $error("outputs not clear");
	chk_w_resp: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	chk_b_once: assert property (s_axi_bvalid && s_axi_bready
		|=> !s_axi_bvalid) else $error("response repeated");
	chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	chk_rd_zero: assert property (s_axi_rvalid |->
		(s_axi_rdata & ~(PSR_CTRL_A_IMPL | PSR_CTRL_B_IMPL)) == 32'h0)
		else $error("unused bit set");
	chk_cap_a: assert property ($rose(comparator_zero_reset) |->
		capability_word_two[24]) else $error("absent unit reset");
	chk_cap_b: assert property ((port_reset & ~$past(port_reset) &
		~capability_word_four[4:0]) == 5'h00) else $error("absent port reset");
	// word lands one edge after bvalid rises, the output one edge later
	chk_rst_hold: assert property (!$stable(outs) |->
		$past(s_axi_bvalid, 2)) else $error("reset changed without write");
	cover property ($rose(comparator_zero_reset));
	cover property ($rose(port_reset[4]));
	cover property ($rose(aresetn));
endmodule
bind psr_ctrl psr_checker u_chk (
	.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rdata(s_axi_rdata),
	.capability_word_two(capability_word_two),
	.capability_word_four(capability_word_four),
	.comparator_zero_reset(comparator_zero_reset),
	.gp_counter_two_reset(gp_counter_two_reset),
	.port_reset(port_reset)
);
`default_nettype wire

// ---- sim/psr_ctrl_bench.sv ----
/* self-checking bench of psr_ctrl with an integer model.
 assumes no fixed answer latency; only the watchdog ends a wait. */
`timescale 1ns/1ps
`default_nettype none
module psr_ctrl_bench
	import psr_pkg::*;
;
	logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	// ready held high: every answer is taken at once
	logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
	logic [31:0] s_axi_wdata = '0, capability_word_two = '0;
	logic [31:0] capability_word_four = '0, s_axi_rdata, ea = '0, eb = '0;
	logic [3:0] s_axi_wstrb = '0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, comparator_zero_reset, gp_counter_two_reset;
	logic gp_counter_one_reset, gp_counter_zero_reset, quad_decoder_zero_reset;
	logic sync_serial_zero_reset, serial_port_one_reset, serial_port_zero_reset;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [4:0] port_reset;
	logic [7:0] ra;
	int n_fail = 0, n_checks = 0;
	assign ra = {comparator_zero_reset, gp_counter_two_reset,
		gp_counter_one_reset, gp_counter_zero_reset, quad_decoder_zero_reset,
		sync_serial_zero_reset, serial_port_one_reset, serial_port_zero_reset};
	psr_ctrl dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.capability_word_two(capability_word_two),
		.capability_word_four(capability_word_four),
		.comparator_zero_reset(comparator_zero_reset),
		.gp_counter_two_reset(gp_counter_two_reset),
		.gp_counter_one_reset(gp_counter_one_reset),
		.gp_counter_zero_reset(gp_counter_zero_reset),
		.quad_decoder_zero_reset(quad_decoder_zero_reset),
		.sync_serial_zero_reset(sync_serial_zero_reset),
		.serial_port_one_reset(serial_port_one_reset),
		.serial_port_zero_reset(serial_port_zero_reset),
		.port_reset(port_reset)
	);
	always #5 aclk = ~aclk;
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	function automatic logic [1:0] resp(input logic [11:0] a);
		return (a == PSR_OFF_CTRL_A || a == PSR_OFF_CTRL_B) ?
			PSR_RESP_OKAY : PSR_RESP_SLVERR;
	endfunction
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] m;
		m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		chk(s_axi_bresp, resp(a));
		if (a == PSR_OFF_CTRL_A) m = m & capability_word_two & PSR_CTRL_A_IMPL;
		if (a == PSR_OFF_CTRL_B) m = m & capability_word_four & PSR_CTRL_B_IMPL;
		if (a == PSR_OFF_CTRL_A) ea = ea & ~m | d & m;
		if (a == PSR_OFF_CTRL_B) eb = eb & ~m | d & m;
	endtask
	// outputs lag the word by one edge, so a read after a write sees them
	task automatic rd(input logic [11:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		chk(s_axi_rdata, a == PSR_OFF_CTRL_A ? ea :
			a == PSR_OFF_CTRL_B ? eb : 32'h0);
		chk(s_axi_rresp, resp(a));
		chk(ra, {ea[24], ea[18:16], ea[8], ea[4], ea[1:0]});
		chk(port_reset, eb[4:0]);
	endtask
	initial begin
		#100000;
		n_fail++;
		print_verdict;
	end
	initial begin
		logic [11:0] a;
		a = 12'($urandom(32'h5EA8FCA4));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk({s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid,
			s_axi_rvalid}, 32'h0000001C);
		rd(PSR_OFF_CTRL_A);
		rd(PSR_OFF_CTRL_B);
		$display("test 1 done");
		capability_word_two <= 32'hFFFFFFFF;
		capability_word_four <= 32'hFFFFFFFF;
		for (int i = 0; i < 32; i++) begin
			wr(PSR_OFF_CTRL_A, 32'h1 << i, 4'hF);
			rd(PSR_OFF_CTRL_A);
			wr(PSR_OFF_CTRL_B, 32'h1 << i, 4'hF);
			rd(PSR_OFF_CTRL_B);
		end
		$display("test 2 done");
		repeat (60) begin
			capability_word_two <= $urandom;
			capability_word_four <= $urandom;
			a = PSR_OFF_CTRL_A + 12'(4 * ($urandom % 3));
			wr(a, $urandom, 4'($urandom));
			rd(a);
		end
		$display("test 3 done");
		capability_word_two <= 32'hFFFFFFFF;
		capability_word_four <= 32'hFFFFFFFF;
		wr(PSR_OFF_CTRL_A, 32'hFFFFFFFF, 4'hF);
		wr(PSR_OFF_CTRL_B, 32'hFFFFFFFF, 4'hF);
		rd(PSR_OFF_CTRL_A);
		rd(PSR_OFF_CTRL_B);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		ea = 32'h0;
		eb = 32'h0;
		@(posedge aclk);
		chk({s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid,
			s_axi_rvalid}, 32'h0000001C);
		rd(PSR_OFF_CTRL_A);
		rd(PSR_OFF_CTRL_B);
		$display("test 4 done");
		print_verdict;
	end
endmodule
`default_nettype wire
